// ---- common/supply_level_consts.svh ----
`ifndef SUPPLY_LEVEL_CONSTS_SVH
`define SUPPLY_LEVEL_CONSTS_SVH

// apb register byte offsets
`define REG_CONTROL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STATUS 12'h008
`define REG_IRQ_ENABLE 12'h00c
`define REG_IRQ_CLEAR 12'h010

// control register fields
`define CTL_HEAVY 0
`define CTL_SAMPLE 1
`define CTL_FAST 2
`define CTL_LOWV 3

// status register fields
`define STS_RESULT 0
`define STS_DET_ON 1
`define STS_SETTLED 2
`define STS_HEAVY 3
`define STS_HOLD 4

// interrupt event bits
`define EV_SETTLED 0
`define EV_HOLD_DONE 1
`define EV_SAMPLE_LONG 2
`define EV_WIDTH 3

// timing figures in their own units
`define CLK_MHZ 100
`define SETTLE_US 100
`define HOLD_MS 600
`define RECOVER_MS 1000
`define SAMPLE_MAX_MS 10

// derived cycle counts (least times round up, longest round down)
`define SETTLE_CYCLES (`SETTLE_US * `CLK_MHZ)
`define HOLD_CYCLES (`HOLD_MS * 1000 * `CLK_MHZ)
`define RECOVER_CYCLES (`RECOVER_MS * 1000 * `CLK_MHZ)
`define SAMPLE_MAX_CYCLES (`SAMPLE_MAX_MS * 1000 * `CLK_MHZ)

`endif

// ---- common/supply_level_pkg.sv ----
package supply_level_pkg;

  typedef enum logic [1:0] {
    det_off,
    det_settling,
    det_ready
  } det_state_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic [31:0] prdata_next_unused;
  } unused_pad_t;

endpackage

// ---- common/detector_if.sv ----
`timescale 1ns/100ps
interface detector_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface

// ---- core/cycle_timer.sv ----
`timescale 1ns/100ps
// one-shot counter: start loads the count, done pulses when it runs out
module cycle_timer #(
  parameter int unsigned COUNT = 10000,
  parameter int WIDTH = 32
)(
  input wire logic pclk,
  input wire logic presetn,
  detector_if.timer tmr
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic busy;
    logic done;
  } tstate_t;

  tstate_t state;
  tstate_t next_state;

  initial
  begin
    if (COUNT < 1 || WIDTH > 32 || COUNT >= (64'h1 << WIDTH))
      $error("cycle_timer: count does not fit");
  end

  always_comb
  begin
    next_state = state;
    next_state.done = 1'b0;
    if (tmr.start)
    begin
      next_state.count = WIDTH'(COUNT - 1);
      next_state.busy = 1'b1;
    end
    else if (state.busy)
    begin
      if (state.count == '0)
      begin
        next_state.busy = 1'b0;
        next_state.done = 1'b1;
      end
      else
        next_state.count = state.count - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= '0;
    else
      state <= next_state;
  end

  assign tmr.busy = state.busy;
  assign tmr.done = state.done;
endmodule

// ---- core/supply_level_detect_control.sv ----
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "supply_level_consts.svh"
module supply_level_detect_control #(
  parameter int unsigned SETTLE_CYCLES = `SETTLE_CYCLES,
  parameter int unsigned HOLD_CYCLES = `HOLD_CYCLES,
  parameter int unsigned RECOVER_CYCLES = `RECOVER_CYCLES,
  parameter int unsigned SAMPLE_MAX_CYCLES = `SAMPLE_MAX_CYCLES
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_low,
  input wire logic low_voltage_variant,
  output logic detector_power,
  output logic heavy_load_mode,
  output logic irq
);
  import supply_level_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] prdata;
    logic pslverr;
    det_state_t det;
    logic heavy;
    logic sample;
    logic fast;
    logic result;
    logic hold_active;
    logic recovering;
    logic [`EV_WIDTH-1:0] irq_status;
    logic [`EV_WIDTH-1:0] irq_enable;
  } state_t;

  state_t state;
  state_t next_state;

  detector_if settle_if ();
  detector_if hold_if ();
  detector_if recover_if ();
  detector_if long_if ();

  logic wr;
  logic rd;
  logic det_on;
  logic heavy_req;
  logic [`EV_WIDTH-1:0] events;

  initial
  begin
    if (SETTLE_CYCLES < 1 || HOLD_CYCLES < 1 || RECOVER_CYCLES < 1 ||
        SAMPLE_MAX_CYCLES < 1)
      $error("supply_level_detect_control: counts must be at least 1");
  end

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  // ----------------------------------------------------------------
  // access legality
  // ----------------------------------------------------------------
  // status words are read-only and the clear word is write-only; a
  // refused access changes nothing and only raises pslverr
  function automatic logic access_error(input logic [11:0] a,
                                        input logic w);
    if (hit(a, `REG_CONTROL) || hit(a, `REG_IRQ_ENABLE))
      access_error = 1'b0;
    else if (hit(a, `REG_STATUS) || hit(a, `REG_IRQ_STATUS))
      access_error = w;
    else if (hit(a, `REG_IRQ_CLEAR))
      access_error = !w;
    else
      access_error = 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  cycle_timer #(.COUNT(SETTLE_CYCLES)) u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .tmr(settle_if)
  );
  cycle_timer #(.COUNT(HOLD_CYCLES)) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .tmr(hold_if)
  );
  cycle_timer #(.COUNT(RECOVER_CYCLES)) u_recover (
    .pclk(pclk),
    .presetn(presetn),
    .tmr(recover_if)
  );
  cycle_timer #(.COUNT(SAMPLE_MAX_CYCLES)) u_long (
    .pclk(pclk),
    .presetn(presetn),
    .tmr(long_if)
  );

  // ----------------------------------------------------------------
  // apb access and detector sequencing
  // ----------------------------------------------------------------
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign det_on = state.heavy || state.sample;
  assign heavy_req = wr && hit(paddr, `REG_CONTROL) &&
                     pwdata[`CTL_HEAVY];

  // detector powers up on either source; settle timer restarts on power-up
  assign settle_if.start = (state.det == det_off) && det_on;
  // fast clock: a write of one arms the minimum hold of heavy mode
  assign hold_if.start = heavy_req && state.fast;
  // low-voltage variant needs a recovery wait after heavy drive
  assign recover_if.start = wr && hit(paddr, `REG_CONTROL) &&
                            state.heavy && !pwdata[`CTL_HEAVY] &&
                            low_voltage_variant && !state.sample;
  assign long_if.start = wr && hit(paddr, `REG_CONTROL) &&
                         pwdata[`CTL_SAMPLE] && !state.sample;

  // a late done from a run cut short by power-down must not raise the flag
  assign events[`EV_SETTLED] = settle_if.done &&
                               (state.det == det_settling) && det_on;
  assign events[`EV_HOLD_DONE] = hold_if.done;
  assign events[`EV_SAMPLE_LONG] = long_if.done && state.sample &&
                                   state.heavy;

  always_comb
  begin
    next_state = state;
    next_state.pslverr = (wr || rd) && access_error(paddr, pwrite);
    next_state.hold_active = hold_if.busy || hold_if.start;
    // the flag, not the timer, says whether recovery is pending, so a
    // sample pulse can end the wait while the timer runs out unseen
    if (recover_if.start)
      next_state.recovering = 1'b1;
    else if (recover_if.done)
      next_state.recovering = 1'b0;
    if (wr)
    begin
      if (hit(paddr, `REG_CONTROL))
      begin
        next_state.fast = pwdata[`CTL_FAST];
        next_state.sample = pwdata[`CTL_SAMPLE];
        if (pwdata[`CTL_HEAVY])
          next_state.heavy = 1'b1;
        else if (!(state.hold_active && state.fast))
          next_state.heavy = 1'b0;
        // leaving sample mode under heavy drive ends any recovery wait
        // only a pulse long enough for the detector to settle counts
        if (state.sample && !pwdata[`CTL_SAMPLE] &&
            state.det == det_ready)
          next_state.recovering = 1'b0;
      end
      else if (hit(paddr, `REG_IRQ_ENABLE))
        next_state.irq_enable = pwdata[`EV_WIDTH-1:0];
      else if (hit(paddr, `REG_IRQ_CLEAR))
        next_state.irq_status = state.irq_status & ~pwdata[`EV_WIDTH-1:0];
      else if (!hit(paddr, `REG_STATUS) && !hit(paddr, `REG_IRQ_STATUS))
        next_state.pslverr = 1'b1;
    end
    // set wins over a simultaneous clear
    next_state.irq_status = next_state.irq_status | events;

    case (state.det)
      det_off:
        if (det_on)
          next_state.det = det_settling;
      det_settling:
        if (!det_on)
          next_state.det = det_off;
        else if (settle_if.done)
          next_state.det = det_ready;
      det_ready:
        if (!det_on)
          next_state.det = det_off;
      default:
        next_state.det = det_off;
    endcase

    // result tracks the comparator only when settled; on power-down it
    // keeps the last settled outcome
    if (state.det == det_ready && det_on)
      next_state.result = comparator_low;

    if (rd)
    begin
      next_state.prdata = '0;
      if (hit(paddr, `REG_CONTROL))
      begin
        next_state.prdata[`CTL_HEAVY] = state.heavy;
        next_state.prdata[`CTL_SAMPLE] = state.result;
        next_state.prdata[`CTL_FAST] = state.fast;
        next_state.prdata[`CTL_LOWV] = low_voltage_variant;
      end
      else if (hit(paddr, `REG_STATUS))
      begin
        next_state.prdata[`STS_RESULT] = state.result;
        next_state.prdata[`STS_DET_ON] = det_on;
        next_state.prdata[`STS_SETTLED] = (state.det == det_ready);
        next_state.prdata[`STS_HEAVY] = state.heavy || state.recovering;
        next_state.prdata[`STS_HOLD] = state.hold_active;
      end
      else if (hit(paddr, `REG_IRQ_STATUS))
        next_state.prdata[`EV_WIDTH-1:0] = state.irq_status;
      else if (hit(paddr, `REG_IRQ_ENABLE))
        next_state.prdata[`EV_WIDTH-1:0] = state.irq_enable;
      else
        next_state.pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= '0;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // a registered answer would appear only the cycle after the access phase,
  // which pready=1 ends at once; read data would be one access late,
  // so reads present the live combinational value instead
  always_comb
  begin
    prdata = '0;
    if (rd)
    begin
      if (hit(paddr, `REG_CONTROL))
      begin
        prdata[`CTL_HEAVY] = state.heavy;
        prdata[`CTL_SAMPLE] = state.result;
        prdata[`CTL_FAST] = state.fast;
        prdata[`CTL_LOWV] = low_voltage_variant;
      end
      else if (hit(paddr, `REG_STATUS))
      begin
        prdata[`STS_RESULT] = state.result;
        prdata[`STS_DET_ON] = det_on;
        prdata[`STS_SETTLED] = (state.det == det_ready);
        prdata[`STS_HEAVY] = state.heavy || state.recovering;
        prdata[`STS_HOLD] = state.hold_active;
      end
      else if (hit(paddr, `REG_IRQ_STATUS))
        prdata[`EV_WIDTH-1:0] = state.irq_status;
      else if (hit(paddr, `REG_IRQ_ENABLE))
        prdata[`EV_WIDTH-1:0] = state.irq_enable;
    end
  end

  assign pslverr = psel && penable && access_error(paddr, pwrite);
  assign detector_power = det_on;
  // heavy protection stays applied through the low-voltage recovery wait
  assign heavy_load_mode = state.heavy || state.recovering;
  assign irq = |(state.irq_status & state.irq_enable);
endmodule

// ---- tb/supply_level_chk.sv ----
`timescale 1ns/100ps
`include "supply_level_consts.svh"
module supply_level_chk #(
  parameter int unsigned HOLD_CYCLES = 50
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic low_voltage_variant,
  input wire logic detector_power,
  input wire logic heavy_load_mode,
  input wire logic irq
);
  logic acc;
  logic wr_ctl;
  logic fast_q;
  logic [31:0] hold_cnt;
  assign acc = psel && penable;
  assign wr_ctl = acc && pwrite && paddr == `REG_CONTROL;
  // shadow of the fast bit and a hold countdown one short of the device's
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      fast_q <= 1'b0;
      hold_cnt <= 32'h0;
    end
    else
    begin
      if (wr_ctl)
        fast_q <= pwdata[2];
      if (wr_ctl && pwdata[0] && fast_q && hold_cnt == 0)
        hold_cnt <= HOLD_CYCLES - 1;
      else if (hold_cnt != 0)
        hold_cnt <= hold_cnt - 1;
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (acc |-> pready)
    else $error("pready low in access");
  a_bad_addr: assert property (acc && paddr > `REG_IRQ_CLEAR |-> pslverr)
    else $error("no error on unmapped address");
  a_heavy_on: assert property (
    wr_ctl && pwdata[`CTL_HEAVY] |=> heavy_load_mode && detector_power)
    else $error("heavy write did not power detector");
  a_sample_on: assert property (
    wr_ctl && pwdata[`CTL_SAMPLE] |=> detector_power)
    else $error("sample write did not power detector");
  a_hold_keep: assert property (
    hold_cnt != 0 |-> heavy_load_mode)
    else $error("heavy mode dropped during hold");
  a_power_still: assert property (
    !$past(wr_ctl) && !low_voltage_variant |-> $stable(detector_power))
    else $error("detector power moved without write");
  a_lowv_bit: assert property (acc && !pwrite && paddr == `REG_CONTROL
    |-> prdata[`CTL_LOWV] == low_voltage_variant)
    else $error("variant bit wrong");
  a_ro_write: assert property (acc && pwrite &&
    (paddr == `REG_STATUS || paddr == `REG_IRQ_STATUS) |-> pslverr)
    else $error("write to read-only register accepted");
  a_std_release: assert property (
    wr_ctl && pwdata[1:0] == 2'b00 && !fast_q && !low_voltage_variant
    |=> !heavy_load_mode)
    else $error("heavy mode not released");
  a_irq_off: assert property (acc && pwrite && paddr == `REG_IRQ_ENABLE
    && pwdata[2:0] == 3'h0 |=> !irq)
    else $error("irq high with all disabled");
endmodule
bind supply_level_detect_control supply_level_chk #(
  .HOLD_CYCLES(HOLD_CYCLES)
) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .low_voltage_variant(low_voltage_variant),
  .detector_power(detector_power), .heavy_load_mode(heavy_load_mode),
  .irq(irq)
);

// ---- tb/supply_level_detect_control_test.sv ----
`timescale 1ns/100ps
`include "supply_level_consts.svh"
module supply_level_detect_control_test;
  localparam int S = 20;
  localparam int H = 50;
  localparam int R = 80;
  localparam int M = 30;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rv;
  logic pready;
  logic pslverr;
  logic err;
  logic comparator_low = 0;
  logic low_voltage_variant = 0;
  logic detector_power;
  logic heavy_load_mode;
  logic irq;
  int failures = 0;
  int n_checks = 0;
  always #5 pclk = ~pclk;
  supply_level_detect_control #(
    .SETTLE_CYCLES(S), .HOLD_CYCLES(H), .RECOVER_CYCLES(R),
    .SAMPLE_MAX_CYCLES(M)
  ) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparator_low(comparator_low),
    .low_voltage_variant(low_voltage_variant),
    .detector_power(detector_power), .heavy_load_mode(heavy_load_mode),
    .irq(irq)
  );
  // ---------------------------------------------
  // bus tasks
  // ---------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task flag(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial
  begin
    #50000;
    failures++;
    report_and_stop();
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    comparator_low <= 1'b1;
    wr(`REG_CONTROL, 32'h1);
    repeat (S + 3) @(posedge pclk);
    flag(detector_power, 1'b1);
    rd(`REG_STATUS, 32'hf);
    wr(`REG_IRQ_ENABLE, 32'h1);
    @(posedge pclk);
    flag(irq, 1'b1);
    wr(`REG_IRQ_CLEAR, 32'h7);
    @(posedge pclk);
    flag(irq, 1'b0);
    wr(`REG_CONTROL, 32'h0);
    comparator_low <= 1'b0;
    rd(`REG_CONTROL, 32'h2);
    $display("done: slow heavy");
    wr(`REG_CONTROL, 32'h2);
    rd(`REG_STATUS, 32'h3);
    repeat (S + 3) @(posedge pclk);
    wr(`REG_CONTROL, 32'h0);
    rd(`REG_CONTROL, 32'h0);
    $display("done: slow sample");
    wr(`REG_CONTROL, 32'h4);
    wr(`REG_CONTROL, 32'h5);
    wr(`REG_CONTROL, 32'h4);
    rd(`REG_STATUS, 32'h1a);
    comparator_low <= 1'b1;
    wr(`REG_CONTROL, 32'h6);
    repeat (S + 3) @(posedge pclk);
    wr(`REG_CONTROL, 32'h4);
    rd(`REG_CONTROL, 32'h7);
    comparator_low <= 1'b0;
    repeat (H) @(posedge pclk);
    wr(`REG_CONTROL, 32'h4);
    @(posedge pclk);
    flag(heavy_load_mode, 1'b0);
    rd(`REG_IRQ_STATUS, 32'h3);
    wr(`REG_IRQ_CLEAR, 32'h7);
    wr(`REG_CONTROL, 32'h0);
    $display("done: fast hold");
    wr(`REG_CONTROL, 32'h1);
    wr(`REG_CONTROL, 32'h3);
    repeat (M + 3) @(posedge pclk);
    rd(`REG_IRQ_STATUS, 32'h5);
    wr(`REG_IRQ_ENABLE, 32'h4);
    @(posedge pclk);
    flag(irq, 1'b1);
    wr(`REG_CONTROL, 32'h1);
    wr(`REG_IRQ_CLEAR, 32'h7);
    @(posedge pclk);
    flag(irq, 1'b0);
    wr(`REG_IRQ_ENABLE, 32'h0);
    wr(`REG_CONTROL, 32'h0);
    $display("done: long sample");
    low_voltage_variant <= 1'b1;
    wr(`REG_CONTROL, 32'h1);
    wr(`REG_CONTROL, 32'h0);
    repeat (R / 2) @(posedge pclk);
    flag(heavy_load_mode, 1'b1);
    repeat (R) @(posedge pclk);
    flag(heavy_load_mode, 1'b0);
    wr(`REG_CONTROL, 32'h1);
    wr(`REG_CONTROL, 32'h0);
    wr(`REG_CONTROL, 32'h2);
    repeat (S) @(posedge pclk);
    wr(`REG_CONTROL, 32'h0);
    @(posedge pclk);
    flag(heavy_load_mode, 1'b0);
    rd(`REG_CONTROL, 32'h8);
    flag(heavy_load_mode, 1'b0);
    $display("done: recovery");
    xfer(1'b0, 12'h020, 32'h0);
    flag(err, 1'b1);
    wr(`REG_STATUS, 32'h1f);
    flag(err, 1'b1);
    xfer(1'b0, `REG_IRQ_CLEAR, 32'h0);
    flag(err, 1'b1);
    rd(`REG_STATUS, 32'h0);
    flag(err, 1'b0);
    $display("done: bad access");
    report_and_stop();
  end
endmodule
